/* File: design/ppo_oc_filter.sv */
// one overcurrent sense filter channel: lockout, single and double low pulse detection
`timescale 1ns/1ps
module ppo_oc_filter (
  input wire logic clk, // core clock
  input wire logic reset, // synchronous, active high
  input wire logic tick, // 1 ms tick pulse
  input wire logic pwr_en, // channel power is on
  input wire logic pin_low, // sensed pin level is low
  input wire ppo_pkg::ppo_cfg_t cfg, // timing configuration
  output logic det // one-cycle overcurrent detection
);
  import ppo_pkg::*;

  logic pwr_d; // power enable one cycle ago
  logic low_d; // pin low one cycle ago
  logic done; // already reported during this power-on
  logic [7:0] lock_cnt; // lockout ms remaining
  logic [7:0] win_cnt; // double-pulse window ms remaining
  logic [3:0] low_ms; // ms of unbroken low level

  wire pwr_rise = pwr_en & ~pwr_d; // power switched on this cycle
  wire armed = pwr_en & (lock_cnt == 8'h00) & ~pwr_rise; // pin is watched
  wire low_start = pin_low & ~low_d; // a new group of low samples begins
  wire single_hit = armed & pin_low & (low_ms >= cfg.min_width) & ~done;
  wire double_hit = armed & low_start & (win_cnt != 8'h00) & ~done;

  ////////////////////////////////////////////////////////////////////////////
  // edge history
  always_ff @(posedge clk) begin
    if (reset) begin
      pwr_d <= 1'b0;
      low_d <= 1'b0;
    end else begin
      pwr_d <= pwr_en;
      low_d <= pin_low;
    end
  end

  // lockout timer loads at power-on, pin is ignored until it expires
  always_ff @(posedge clk) begin
    if (reset || !pwr_en) begin
      lock_cnt <= 8'h00;
    end else if (pwr_rise) begin
      lock_cnt <= cfg.lockout;
    end else if (tick && lock_cnt != 8'h00) begin
      lock_cnt <= lock_cnt - 8'h01;
    end
  end

  // unbroken low width in ms, any high sample restarts it
  always_ff @(posedge clk) begin
    if (reset || !armed || !pin_low) begin
      low_ms <= 4'h0;
    end else if (tick && low_ms != 4'hF) begin
      low_ms <= low_ms + 4'h1;
    end
  end

  // window opens at the first low group and runs for the configured ms
  always_ff @(posedge clk) begin
    if (reset || !armed) begin
      win_cnt <= 8'h00;
    end else if (low_start && win_cnt == 8'h00) begin
      win_cnt <= cfg.window;
    end else if (tick && win_cnt != 8'h00) begin
      win_cnt <= win_cnt - 8'h01;
    end
  end

  // one report per power-on so a held fault does not repeat
  always_ff @(posedge clk) begin
    if (reset || !pwr_en) begin
      done <= 1'b0;
      det <= 1'b0;
    end else begin
      done <= done | single_hit | double_hit;
      det <= single_hit | double_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_lockout_quiet;
    @(posedge clk) disable iff (reset) (lock_cnt != 8'h00) |=> !det;
  endproperty
  a_lockout_quiet: assert property (p_lockout_quiet) else $error("detect during lockout");

  property p_single;
    @(posedge clk) disable iff (reset)
      (armed && pin_low && low_ms >= cfg.min_width && !done) |=> det ##1 !det;
  endproperty
  a_single: assert property (p_single) else $error("single pulse not reported once");

  property p_double;
    @(posedge clk) disable iff (reset)
      (armed && pin_low && !low_d && win_cnt != 8'h00 && !done) |=> det;
  endproperty
  a_double: assert property (p_double) else $error("second low group not reported");

  property p_det_armed;
    @(posedge clk) disable iff (reset) det |-> $past(armed) && $past(pin_low);
  endproperty
  a_det_armed: assert property (p_det_armed) else $error("detect without armed low");
endmodule // ppo_oc_filter

/* File: design/ppo_pkg.sv */
// package: register map, field layout, reset values and timing for port power control
package ppo_pkg;
  localparam int NPORT = 6; // downstream ports
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_LOCKOUT = 16'h30E1; // power-on lockout time
  localparam logic [15:0] IDX_MIN_WIDTH = 16'h30EA; // single-pulse minimum width
  localparam logic [15:0] IDX_WINDOW = 16'h30EB; // double-pulse rolling window
  localparam logic [15:0] IDX_POWER = 16'h30F0; // per-port power enable
  localparam logic [15:0] IDX_GANG = 16'h30F1; // ganged mode select
  localparam logic [15:0] IDX_STATUS = 16'h30F2; // sticky overcurrent flags
  localparam logic [15:0] IDX_MASK = 16'h30F3; // interrupt mask
  localparam logic [15:0] ADDR_LOCKOUT = 16'(IDX_LOCKOUT * 4);
  localparam logic [15:0] ADDR_MIN_WIDTH = 16'(IDX_MIN_WIDTH * 4);
  localparam logic [15:0] ADDR_WINDOW = 16'(IDX_WINDOW * 4);
  localparam logic [15:0] ADDR_POWER = 16'(IDX_POWER * 4);
  localparam logic [15:0] ADDR_GANG = 16'(IDX_GANG * 4);
  localparam logic [15:0] ADDR_STATUS = 16'(IDX_STATUS * 4);
  localparam logic [15:0] ADDR_MASK = 16'(IDX_MASK * 4);
  // field layout
  localparam int MINW_MSB = 3; // min width field bits 3:0, 7:4 reserved
  localparam int GANG_BIT = 0; // gang select bit
  // reset values
  localparam logic [3:0] RST_MIN_WIDTH = 4'h5; // 5 ms
  localparam logic [7:0] RST_WINDOW = 8'h14; // 20 ms
  localparam logic [7:0] RST_LOCKOUT = 8'h0A; // 10 ms
  localparam logic [NPORT-1:0] RST_PORTS = 6'h00; // power, status, mask
  // timing
  localparam int CLK_PERIOD_NS = 100; // 10 MHz core clock
  localparam int TICK_PERIOD_NS = 1000000; // 1 ms timing tick
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  // timing configuration carried to every filter channel
  typedef struct packed {
    logic [3:0] min_width; // single-pulse minimum width, ms
    logic [7:0] window; // double-pulse window, ms
    logic [7:0] lockout; // lockout after power-on, ms
  } ppo_cfg_t;
endpackage

/* File: design/ppo_port_power_ctl.sv */
// downstream port power control and overcurrent sense with an APB register slave
// What this block does
// - ganged mode uses one shared pin for all
// - ganged overcurrent flags every downstream port
// - reset selects individual mode, one pin per port
// - ganged mode set only by configuration
// - power off drives pin low, pull-up off
// - power on releases pin, pull-up on
// - enabled port pin sampled, low means fault
// - unbroken low for minimum width reports fault
// - two low groups within window report fault
// - pin ignored during lockout after power-on
// - filtering tolerates short transient low levels
// - min width field 3:0, default five ms
// - window field 7:0 in ms, default 20
// - lockout eight bits in ms, default ten
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
module ppo_port_power_ctl #(
  parameter int TICK_CYCLES = ppo_pkg::TICK_CYCLES // core clocks per 1 ms tick
) (
  input wire logic CLK, // core clock, 10 MHz
  input wire logic RESET, // synchronous, active high
  input wire logic [15:0] PADDR, // apb byte address
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb access phase
  input wire logic PWRITE, // apb write
  input wire logic [31:0] PWDATA, // apb write data
  output logic [31:0] PRDATA, // apb read data
  output logic PREADY, // apb ready
  output logic PSLVERR, // apb error, unmapped address
  input wire logic CFG_STAGE, // high during hub configuration stage
  input wire logic OTP_LOAD, // one-cycle pulse: load otp settings
  input wire logic OTP_GANG, // ganged mode value from otp
  input wire logic [ppo_pkg::NPORT-1:0] PORT_CTL_PIN_IN, // per-port pin level
  output logic [ppo_pkg::NPORT-1:0] PORT_CTL_PIN_OUT, // per-port drive value
  output logic [ppo_pkg::NPORT-1:0] PORT_CTL_PIN_OE_N, // per-port enable, low drives
  output logic [ppo_pkg::NPORT-1:0] PORT_CTL_PULLUP_EN, // per-port pull-up enable
  input wire logic SHARED_POWER_PIN_IN, // ganged pin level
  output logic SHARED_POWER_PIN_OUT, // ganged pin drive value
  output logic SHARED_POWER_PIN_OE_N, // ganged pin enable, low drives
  output logic SHARED_POWER_PULLUP_EN, // ganged pin pull-up enable
  output logic IRQ // level interrupt
);
  import ppo_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  ppo_cfg_t cfg; // timing settings
  logic [NPORT-1:0] power; // per-port power enable
  logic gang_mode; // ganged mode selected
  logic [NPORT-1:0] status; // sticky overcurrent flags
  logic [NPORT-1:0] mask; // interrupt enables
  logic [13:0] tick_cnt; // tick prescaler
  logic tick; // 1 ms pulse
  wire [NPORT:0] det; // filter detections, top entry is the shared pin

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  wire setup = PSEL & ~PENABLE; // setup phase
  wire access = PSEL & PENABLE; // access phase, always ready
  wire wr = access & PWRITE; // write takes effect
  wire sel_lock = PADDR == ADDR_LOCKOUT;
  wire sel_minw = PADDR == ADDR_MIN_WIDTH;
  wire sel_win = PADDR == ADDR_WINDOW;
  wire sel_pwr = PADDR == ADDR_POWER;
  wire sel_gang = PADDR == ADDR_GANG;
  wire sel_stat = PADDR == ADDR_STATUS;
  wire sel_mask = PADDR == ADDR_MASK;
  // any address outside the map answers with an error and stores nothing
  wire mapped = sel_lock | sel_minw | sel_win | sel_pwr | sel_gang | sel_stat | sel_mask;
  wire rd_stat = access & ~PWRITE & sel_stat; // status read, clears what was read
  // only bits already handed to software are cleared, so a late event is kept
  wire [NPORT-1:0] stat_clr = rd_stat ? PRDATA[NPORT-1:0] : '0;
  // a late gang write is dropped quietly, with no error response
  wire gang_wr = wr & sel_gang & CFG_STAGE; // ignored outside configuration
  wire [31:0] rd_mux =
    sel_lock ? {24'h000000, cfg.lockout} :
    sel_minw ? {28'h0000000, cfg.min_width} :
    sel_win  ? {24'h000000, cfg.window} :
    sel_pwr  ? {26'h0000000, power} :
    sel_gang ? {31'h00000000, gang_mode} :
    sel_stat ? {26'h0000000, status} :
    sel_mask ? {26'h0000000, mask} : 32'h00000000;

  // no wait states: every register answers in the first access cycle
  assign PREADY = 1'b1;
  assign PSLVERR = access & ~mapped;

  // read data is captured in setup so it stands through the access phase
  always_ff @(posedge CLK) begin
    if (RESET) begin
      PRDATA <= 32'h00000000;
    end else if (setup && !PWRITE) begin
      PRDATA <= rd_mux;
    end
  end

  // timing, power and mask registers
  always_ff @(posedge CLK) begin
    if (RESET) begin
      cfg.min_width <= RST_MIN_WIDTH;
      cfg.window <= RST_WINDOW;
      cfg.lockout <= RST_LOCKOUT;
      power <= RST_PORTS;
      mask <= RST_PORTS;
    end else if (wr) begin
      if (sel_minw) cfg.min_width <= PWDATA[MINW_MSB:0];
      if (sel_win) cfg.window <= PWDATA[7:0];
      if (sel_lock) cfg.lockout <= PWDATA[7:0];
      if (sel_pwr) power <= PWDATA[NPORT-1:0];
      if (sel_mask) mask <= PWDATA[NPORT-1:0];
    end
  end

  // port mode: individual after reset, ganged only from configuration
  always_ff @(posedge CLK) begin
    if (RESET) begin
      gang_mode <= 1'b0;
    end else if (OTP_LOAD) begin
      gang_mode <= OTP_GANG;
    end else if (gang_wr) begin
      gang_mode <= PWDATA[GANG_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // 1 ms tick from the core clock
  always_ff @(posedge CLK) begin
    if (RESET) begin
      tick_cnt <= 14'h0000;
      tick <= 1'b0;
    end else if (tick_cnt == 14'(TICK_CYCLES - 1)) begin
      tick_cnt <= 14'h0000;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 14'h0001;
      tick <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // filter channels: one per port plus the shared pin
  // in ganged mode any port power bit switches the shared pin on
  // each channel keeps its own lockout, so ports powered apart are timed apart
  wire gang_power = |power; // shared pin powers all ports together
  generate
    for (genvar i = 0; i <= NPORT; i++) begin : g_chan
      wire chan_pwr;
      wire chan_low;
      if (i == NPORT) begin : g_shared
        assign chan_pwr = gang_mode & gang_power;
        assign chan_low = ~SHARED_POWER_PIN_IN;
      end else begin : g_port
        assign chan_pwr = ~gang_mode & power[i];
        assign chan_low = ~PORT_CTL_PIN_IN[i];
      end
      ppo_oc_filter u_filter (
        .clk(CLK),
        .reset(RESET),
        .tick(tick),
        .pwr_en(chan_pwr),
        .pin_low(chan_low),
        .cfg(cfg),
        .det(det[i])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // pin control: drive low while off, release with pull-up while on
  // the pins only ever pull low; the high level comes from the pull-up
  assign PORT_CTL_PIN_OUT = '0;
  assign SHARED_POWER_PIN_OUT = 1'b0;
  assign PORT_CTL_PIN_OE_N = gang_mode ? {NPORT{1'b1}} : power;
  assign PORT_CTL_PULLUP_EN = gang_mode ? {NPORT{1'b0}} : power;
  assign SHARED_POWER_PIN_OE_N = ~gang_mode | gang_power;
  assign SHARED_POWER_PULLUP_EN = gang_mode & gang_power;

  ////////////////////////////////////////////////////////////////////////////
  // sticky overcurrent flags, set wins over the read clear
  wire [NPORT-1:0] oc_set = gang_mode ? {NPORT{det[NPORT]}} : det[NPORT-1:0];
  wire [NPORT-1:0] next_status = (status & ~stat_clr) | oc_set;

  // status register; nothing but the read path clears a flag
  always_ff @(posedge CLK) begin
    if (RESET) begin
      status <= RST_PORTS;
    end else begin
      status <= next_status;
    end
  end

  // level interrupt, follows status and mask with no register stage
  assign IRQ = |(status & mask);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_off_drives;
    @(posedge CLK) disable iff (RESET)
      (!gang_mode && !power[0]) |-> !PORT_CTL_PIN_OE_N[0] && !PORT_CTL_PULLUP_EN[0];
  endproperty
  a_off_drives: assert property (p_off_drives) else $error("off port not driven low");

  property p_on_releases;
    @(posedge CLK) disable iff (RESET)
      (wr && sel_pwr && PWDATA[0] && !gang_mode && !OTP_LOAD)
        |=> PORT_CTL_PIN_OE_N[0] && PORT_CTL_PULLUP_EN[0];
  endproperty
  a_on_releases: assert property (p_on_releases) else $error("on port not released");

  property p_gang_all;
    @(posedge CLK) disable iff (RESET) (gang_mode && det[NPORT]) |=> (&status);
  endproperty
  a_gang_all: assert property (p_gang_all) else $error("ganged fault not on all ports");

  property p_gang_locked;
    @(posedge CLK) disable iff (RESET)
      (!CFG_STAGE && !OTP_LOAD) |=> gang_mode == $past(gang_mode);
  endproperty
  a_gang_locked: assert property (p_gang_locked) else $error("gang mode changed late");

  property p_reset_indiv;
    @(posedge CLK) disable iff (RESET) $fell(RESET) |-> !gang_mode;
  endproperty
  a_reset_indiv: assert property (p_reset_indiv) else $error("not individual after reset");

  property p_tick_once;
    @(posedge CLK) disable iff (RESET) tick |=> !tick;
  endproperty
  a_tick_once: assert property (p_tick_once) else $error("tick longer than a cycle");

  property p_sticky;
    @(posedge CLK) disable iff (RESET)
      (status[0] && !(rd_stat && PRDATA[0])) |=> status[0];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost without read");

  property p_set_wins;
    @(posedge CLK) disable iff (RESET)
      oc_set[0] |=> status[0] && (IRQ || !mask[0]);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost on clear");

  // shared pin held low while ganged with every port off
  property p_sh_off;
    @(posedge CLK) disable iff (RESET)
      (gang_mode && !gang_power) |-> !SHARED_POWER_PIN_OE_N && !SHARED_POWER_PULLUP_EN;
  endproperty
  a_sh_off: assert property (p_sh_off) else $error("shared pin not driven low");

  // shared pin released with pull-up once ganged power is on
  property p_sh_on;
    @(posedge CLK) disable iff (RESET)
      (gang_mode && gang_power) |-> SHARED_POWER_PIN_OE_N && SHARED_POWER_PULLUP_EN;
  endproperty
  a_sh_on: assert property (p_sh_on) else $error("shared pin not released");

  // in ganged mode the per-port pins are left alone
  property p_gang_ports;
    @(posedge CLK) disable iff (RESET)
      gang_mode |-> (&PORT_CTL_PIN_OE_N) && !(|PORT_CTL_PULLUP_EN);
  endproperty
  a_gang_ports: assert property (p_gang_ports) else $error("port pin active in gang mode");

  // the drive value is always low, so an enabled driver pulls low
  property p_drive_zero;
    @(posedge CLK) disable iff (RESET)
      !(|PORT_CTL_PIN_OUT) && !SHARED_POWER_PIN_OUT;
  endproperty
  a_drive_zero: assert property (p_drive_zero) else $error("pin drive value high");

  // a read that returned a flag clears it when no new event arrives
  property p_read_clears;
    @(posedge CLK) disable iff (RESET)
      (rd_stat && PRDATA[0] && !oc_set[0]) |=> !status[0];
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("flag not cleared by read");

  // gang write during configuration lands
  property p_gang_write;
    @(posedge CLK) disable iff (RESET)
      (gang_wr && !OTP_LOAD) |=> gang_mode == $past(PWDATA[GANG_BIT]);
  endproperty
  a_gang_write: assert property (p_gang_write) else $error("gang write lost");

  // otp load sets the port mode
  property p_otp_load;
    @(posedge CLK) disable iff (RESET)
      OTP_LOAD |=> gang_mode == $past(OTP_GANG);
  endproperty
  a_otp_load: assert property (p_otp_load) else $error("otp gang value not loaded");

  // reserved bits of the width register read zero
  property p_minw_rsvd;
    @(posedge CLK) disable iff (RESET)
      (setup && !PWRITE && sel_minw) |=> PRDATA[31:4] == 28'h0000000;
  endproperty
  a_minw_rsvd: assert property (p_minw_rsvd) else $error("reserved width bits set");

  // individual mode: each pin follows its own power bit
  property p_indiv_pins;
    @(posedge CLK) disable iff (RESET)
      !gang_mode |-> PORT_CTL_PULLUP_EN == power && PORT_CTL_PIN_OE_N == power;
  endproperty
  a_indiv_pins: assert property (p_indiv_pins) else $error("port pin not per port");
endmodule // ppo_port_power_ctl

/* File: test/ppo_switch_model.sv */
// external port power switch model with an open-drain overcurrent output
`timescale 1ns/1ps
module ppo_switch_model (
  input wire logic clk, // core clock
  input wire logic oe_n, // hub enable, low drives
  input wire logic drv, // hub drive value
  input wire logic pullup_en, // hub pull-up enable
  input wire logic fault, // overcurrent on this switch
  output logic pin // resolved pin level
);
  logic float_bit = 1'h0; // pattern for an undriven pin
  ////////////////////////////////////////////////////////////
  // a floating pin changes every cycle, so no stale level is sensed
  always @(posedge clk) begin
    float_bit <= ~float_bit;
  end
  // hub drive wins, else the flag pulls low on fault, else the pull-up
  assign pin = !oe_n ? drv : (fault ? 1'h0 : (pullup_en ? 1'h1 : float_bit));
endmodule // ppo_switch_model

/* File: test/tb.sv */
// testbench: apb access, pin drive, overcurrent filtering and ganged mode
`timescale 1ns/1ps
module tb;
  import ppo_pkg::*;
  localparam int MS = 10; // core clocks per simulated ms
  logic clk = 1'h0; // core clock
  logic reset = 1'h1; // synchronous reset
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0; // apb controls
  logic [15:0] paddr = 16'h0; // apb address
  logic [31:0] pwdata = 32'h0, prdata, rdata; // apb data, captured read
  logic pready, pslverr, irq, err; // apb answer, interrupt, captured error
  logic cfg_stage = 1'h0, otp_load = 1'h0, otp_gang = 1'h0; // configuration inputs
  wire [NPORT-1:0] pin_in; // per-port pin levels from the switches
  logic [NPORT-1:0] pin_out, oe_n, pull_en; // per-port pins
  logic [NPORT-1:0] fault = 6'h0; // per-port switch fault
  logic sh_in, sh_out, sh_oe_n, sh_pull, sh_fault = 1'h0; // shared pin
  int bad_count = 0, tests_run = 0; // verdict counters
  ////////////////////////////////////////////////////////////
  always #50 clk = ~clk;
  ppo_port_power_ctl #(.TICK_CYCLES(MS)) uut (.CLK(clk), .RESET(reset), .PADDR(paddr),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .CFG_STAGE(cfg_stage), .OTP_LOAD(otp_load),
    .OTP_GANG(otp_gang), .PORT_CTL_PIN_IN(pin_in), .PORT_CTL_PIN_OUT(pin_out),
    .PORT_CTL_PIN_OE_N(oe_n), .PORT_CTL_PULLUP_EN(pull_en), .SHARED_POWER_PIN_IN(sh_in),
    .SHARED_POWER_PIN_OUT(sh_out), .SHARED_POWER_PIN_OE_N(sh_oe_n),
    .SHARED_POWER_PULLUP_EN(sh_pull), .IRQ(irq));
  // one switch per port and one on the shared pin
  for (genvar i = 0; i < NPORT; i++) begin : g_sw
    ppo_switch_model sw (.clk(clk), .oe_n(oe_n[i]), .drv(pin_out[i]),
      .pullup_en(pull_en[i]), .fault(fault[i]), .pin(pin_in[i]));
  end
  ppo_switch_model sw_sh (.clk(clk), .oe_n(sh_oe_n), .drv(sh_out), .pullup_en(sh_pull),
    .fault(sh_fault), .pin(sh_in));
  ////////////////////////////////////////////////////////////
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // print counts and verdict, then end the run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // one apb transfer: setup, access until pready at an edge, then release
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) begin
      bad_count++;
      stop_test();
    end
    rdata = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // read a register and compare
  task automatic rchk(input logic [15:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(rdata, exp);
  endtask
  // wait whole simulated milliseconds
  task automatic ms(input int n);
    repeat (n * MS) @(posedge clk);
  endtask
  // hold one fault line for a number of clocks
  task automatic pulse(input int port, input int cyc);
    @(posedge clk);
    if (port < NPORT) fault[port] <= 1'h1;
    else sh_fault <= 1'h1;
    repeat (cyc) @(posedge clk);
    fault <= 6'h0;
    sh_fault <= 1'h0;
  endtask
  ////////////////////////////////////////////////////////////
  // hang guard
  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    stop_test();
  end
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'h0;
    rchk(ADDR_MIN_WIDTH, 32'h5);
    rchk(ADDR_WINDOW, 32'h14);
    rchk(ADDR_LOCKOUT, 32'hA);
    rchk(ADDR_GANG, 32'h0);
    rchk(ADDR_POWER, 32'h0);
    rchk(ADDR_STATUS, 32'h0);
    rchk(ADDR_MASK, 32'h0);
    @(negedge clk);
    chk({19'h0, oe_n, sh_oe_n, pull_en}, {19'h0, 6'h0, 1'h1, 6'h0});
    chk({25'h0, pin_out, sh_out}, 32'h0);
    rchk(16'h0100, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'h1, ADDR_MIN_WIDTH, 32'hFF);
    rchk(ADDR_MIN_WIDTH, 32'hF);
    $display("test reset and map done");
    // short timings: width 2 ms, window 5 ms, lockout 2 ms
    apb(1'h1, ADDR_MIN_WIDTH, 32'h2);
    apb(1'h1, ADDR_WINDOW, 32'h5);
    apb(1'h1, ADDR_LOCKOUT, 32'h2);
    apb(1'h1, ADDR_MASK, 32'h3F);
    apb(1'h1, ADDR_POWER, 32'h1);
    @(negedge clk);
    chk({20'h0, oe_n, pull_en}, {20'h0, 6'h01, 6'h01});
    pulse(0, MS); // inside lockout
    ms(4);
    pulse(0, 3); // transient, shorter than the width
    ms(7);
    rchk(ADDR_STATUS, 32'h0);
    pulse(0, 4 * MS);
    ms(1);
    @(negedge clk);
    chk({31'h0, irq}, 32'h1);
    rchk(ADDR_STATUS, 32'h1);
    rchk(ADDR_STATUS, 32'h0);
    $display("test single pulse done");
    apb(1'h1, ADDR_POWER, 32'h3);
    ms(4);
    pulse(1, 3);
    ms(2);
    pulse(1, 3);
    ms(1);
    apb(1'h1, ADDR_MASK, 32'h0);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    apb(1'h1, ADDR_MASK, 32'h3F);
    @(negedge clk);
    chk({31'h0, irq}, 32'h1);
    rchk(ADDR_STATUS, 32'h2);
    $display("test double pulse done");
    apb(1'h1, ADDR_POWER, 32'h0);
    apb(1'h1, ADDR_GANG, 32'h1);
    rchk(ADDR_GANG, 32'h0);
    cfg_stage <= 1'h1;
    apb(1'h1, ADDR_GANG, 32'h1);
    cfg_stage <= 1'h0;
    rchk(ADDR_GANG, 32'h1);
    @(negedge clk);
    chk({25'h0, oe_n, sh_oe_n}, {25'h0, 6'h3F, 1'h0});
    apb(1'h1, ADDR_POWER, 32'h1);
    @(negedge clk);
    chk({30'h0, sh_oe_n, sh_pull}, 32'h3);
    ms(4);
    pulse(NPORT, 4 * MS);
    ms(1);
    rchk(ADDR_STATUS, 32'h3F);
    otp_gang <= 1'h0;
    otp_load <= 1'h1;
    @(posedge clk);
    otp_load <= 1'h0;
    rchk(ADDR_GANG, 32'h0);
    otp_gang <= 1'h1;
    otp_load <= 1'h1;
    @(posedge clk);
    otp_load <= 1'h0;
    rchk(ADDR_GANG, 32'h1);
    $display("test ganged mode done");
    stop_test();
  end
endmodule // tb
